// *** logic/tpmc_consts.svh ***
// Named constants for the tape panel motion control block
`ifndef TPMC_CONSTS_SVH
`define TPMC_CONSTS_SVH

`define TPMC_CLK_PERIOD_NS 10
`define TPMC_DEBOUNCE_US 2000
`define TPMC_SEARCH_FT 25
`define TPMC_PULSES_PER_FT 100

`define TPMC_REG_CMD 12'h000
`define TPMC_REG_STATUS 12'h004
`define TPMC_REG_TRAVEL 12'h008

`define TPMC_CMD_DENS_LSB 0
`define TPMC_CMD_DENS_MSB 1
`define TPMC_CMD_UNIT_LSB 2
`define TPMC_CMD_UNIT_MSB 4
`define TPMC_CMD_GO_FWD 8
`define TPMC_CMD_GO_REV 9
`define TPMC_CMD_GO_REWIND 10
`define TPMC_CMD_STOP 11

`define TPMC_DENS_NONE 2'h0
`define TPMC_DENS_200 2'h1
`define TPMC_DENS_556 2'h2
`define TPMC_DENS_800 2'h3

`define TPMC_UNIT_LAST 4'h7
`define TPMC_TRAVEL_W 16

`endif

// *** logic/tpmc_pkg.sv ***
// Types shared by the tape panel motion control files
`include "tpmc_consts.svh"

package tpmc_pkg;

    typedef enum logic [2:0] {
        TPMC_IDLE,
        TPMC_SEARCH_FWD,
        TPMC_SEARCH_REV,
        TPMC_REWIND,
        TPMC_FWD,
        TPMC_REV
    } tpmc_motion_t;

    typedef struct packed {
        logic local_press;
        logic remote_press;
        logic load_point_press;
        logic rewind_press;
        logic forward_press;
        logic reverse_press;
    } tpmc_press_t;

    typedef struct packed {
        logic motor_fwd;
        logic motor_rev;
        logic motor_rewind;
        logic vacuum_release;
        logic lamp_local;
        logic lamp_remote;
        logic lamp_load_point;
        logic lamp_rewind;
        logic lamp_forward;
        logic lamp_reverse;
        logic [2:0] lamp_density;
        logic lamp_write_enable;
        logic end_marker_lamp;
        logic unit_selected;
    } tpmc_out_t;

    typedef struct packed {
        tpmc_motion_t motion;
        logic remote;
        logic [1:0] density;
        logic [2:0] unit_addr;
        logic [`TPMC_TRAVEL_W-1:0] travel_cnt;
        logic travel_prev;
        tpmc_out_t out;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } tpmc_state_t;

    typedef struct packed {
        logic sync1;
        logic sync2;
        logic stable;
        logic [19:0] cnt;
        logic press;
    } tpmc_deb_state_t;

endpackage : tpmc_pkg

// *** logic/tpmc_debounce.sv ***
// Button synchroniser, debouncer and press pulse generator
module tpmc_debounce import tpmc_pkg::*; #(
    parameter logic [19:0] STABLE_CYCLES = 20'h30d40
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic raw,
    output logic press
);

    tpmc_deb_state_t q;
    tpmc_deb_state_t d;

    always_comb begin
        d = q;
        d.sync1 = raw;
        d.sync2 = q.sync1;
        d.press = 1'b0;
        // Contact must hold its new level for the full window
        if (q.sync2 == q.stable) begin
            d.cnt = '0;
        end else if (q.cnt >= STABLE_CYCLES - 20'h1) begin
            d.cnt = '0;
            d.stable = q.sync2;
            d.press = q.sync2;
        end else begin
            d.cnt = q.cnt + 20'h1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign press = q.press;

endmodule : tpmc_debounce

// *** logic/tpmc_top.sv ***
// Operator panel, tape motion modes and APB registers of the tape transport
//
// Chosen here: the placing of the registers and the APB register port.
`include "tpmc_consts.svh"

module tpmc_top import tpmc_pkg::*; #(
    parameter int unsigned DEBOUNCE_CYCLES =
        (`TPMC_DEBOUNCE_US * 1000) / `TPMC_CLK_PERIOD_NS,
    parameter int unsigned PULSES_PER_FT = `TPMC_PULSES_PER_FT
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic btn_local,
    input wire logic btn_remote,
    input wire logic btn_load_point,
    input wire logic btn_rewind,
    input wire logic btn_forward,
    input wire logic btn_reverse,
    input wire logic start_marker,
    input wire logic end_marker,
    input wire logic ring_present,
    input wire logic travel_pulse,
    input wire logic [3:0] unit_number_switch,
    output logic motor_fwd,
    output logic motor_rev,
    output logic motor_rewind,
    output logic vacuum_release,
    output logic lamp_local,
    output logic lamp_remote,
    output logic lamp_load_point,
    output logic lamp_rewind,
    output logic lamp_forward,
    output logic lamp_reverse,
    output logic [2:0] lamp_density,
    output logic lamp_write_enable,
    output logic end_marker_lamp,
    output logic unit_selected
);

    localparam logic [`TPMC_TRAVEL_W-1:0] SEARCH_LIMIT =
        `TPMC_TRAVEL_W'(`TPMC_SEARCH_FT * PULSES_PER_FT);
    localparam logic [19:0] DEB_CYCLES = 20'(DEBOUNCE_CYCLES);

    localparam tpmc_state_t TPMC_RST = '{
        motion: TPMC_IDLE,
        remote: 1'b0,
        density: `TPMC_DENS_NONE,
        unit_addr: 3'h0,
        travel_cnt: '0,
        travel_prev: 1'b0,
        out: '{lamp_local: 1'b1, default: 1'b0},
        pready: 1'b0,
        pslverr: 1'b0,
        prdata: 32'h0
    };

    // One-of-eight decode of a three-bit address
    function automatic logic [7:0] tpmc_onehot8(input logic [2:0] a);
        tpmc_onehot8 = 8'h01 << a;
    endfunction : tpmc_onehot8

    // Switch positions above the last unit address select nothing
    function automatic logic tpmc_unit_match(input logic [3:0] sw, input logic [2:0] addr);
        logic [7:0] lines;
        lines = tpmc_onehot8(addr);
        tpmc_unit_match = (sw <= `TPMC_UNIT_LAST) && lines[sw[2:0]];
    endfunction : tpmc_unit_match

    // Lamp drive for the selected density, none when no density given
    function automatic logic [2:0] tpmc_density_lamps(input logic [1:0] dens);
        case (dens)
            `TPMC_DENS_200: tpmc_density_lamps = 3'h1;
            `TPMC_DENS_556: tpmc_density_lamps = 3'h2;
            `TPMC_DENS_800: tpmc_density_lamps = 3'h4;
            default: tpmc_density_lamps = 3'h0;
        endcase
    endfunction : tpmc_density_lamps

    tpmc_press_t press;
    tpmc_state_t q;
    tpmc_state_t d;

    tpmc_debounce #(.STABLE_CYCLES(DEB_CYCLES)) u_deb_local (
        .pclk(pclk), .presetn(presetn), .raw(btn_local), .press(press.local_press)
    );
    tpmc_debounce #(.STABLE_CYCLES(DEB_CYCLES)) u_deb_remote (
        .pclk(pclk), .presetn(presetn), .raw(btn_remote), .press(press.remote_press)
    );
    tpmc_debounce #(.STABLE_CYCLES(DEB_CYCLES)) u_deb_load_point (
        .pclk(pclk), .presetn(presetn), .raw(btn_load_point),
        .press(press.load_point_press)
    );
    tpmc_debounce #(.STABLE_CYCLES(DEB_CYCLES)) u_deb_rewind (
        .pclk(pclk), .presetn(presetn), .raw(btn_rewind), .press(press.rewind_press)
    );
    tpmc_debounce #(.STABLE_CYCLES(DEB_CYCLES)) u_deb_forward (
        .pclk(pclk), .presetn(presetn), .raw(btn_forward), .press(press.forward_press)
    );
    tpmc_debounce #(.STABLE_CYCLES(DEB_CYCLES)) u_deb_reverse (
        .pclk(pclk), .presetn(presetn), .raw(btn_reverse), .press(press.reverse_press)
    );

    always_comb begin
        logic travel_step;
        logic access;
        logic wr_cmd;
        logic go_fwd;
        logic go_rev;
        logic go_rewind;
        logic go_stop;
        logic selected;
        travel_step = 1'b0;
        access = 1'b0;
        wr_cmd = 1'b0;
        go_fwd = 1'b0;
        go_rev = 1'b0;
        go_rewind = 1'b0;
        go_stop = 1'b0;
        selected = 1'b0;

        d = q;
        travel_step = travel_pulse && !q.travel_prev;
        d.travel_prev = travel_pulse;

        // APB: a write acts at the edge where pready is sampled high
        access = psel && penable && q.pready;
        wr_cmd = access && pwrite && (paddr == `TPMC_REG_CMD);
        selected = tpmc_unit_match(unit_number_switch, q.unit_addr);
        if (wr_cmd) begin
            d.density = pwdata[`TPMC_CMD_DENS_MSB:`TPMC_CMD_DENS_LSB];
            d.unit_addr = pwdata[`TPMC_CMD_UNIT_MSB:`TPMC_CMD_UNIT_LSB];
            // Motion orders count only for the selected unit in remote mode
            if (q.remote && selected) begin
                go_fwd = pwdata[`TPMC_CMD_GO_FWD];
                go_rev = pwdata[`TPMC_CMD_GO_REV];
                go_rewind = pwdata[`TPMC_CMD_GO_REWIND];
                go_stop = pwdata[`TPMC_CMD_STOP];
            end
        end

        if ((q.motion == TPMC_SEARCH_FWD) && travel_step
                && (q.travel_cnt != SEARCH_LIMIT)) begin
            d.travel_cnt = q.travel_cnt + `TPMC_TRAVEL_W'(1);
        end

        if (press.local_press) begin
            // Full clear; also the halt out of remote mode
            d.motion = TPMC_IDLE;
            d.remote = 1'b0;
            d.density = `TPMC_DENS_NONE;
            d.unit_addr = 3'h0;
            d.travel_cnt = '0;
            d.out.lamp_load_point = 1'b0;
            d.out.end_marker_lamp = 1'b0;
        end else if (press.remote_press) begin
            d.remote = 1'b1;
            d.motion = TPMC_IDLE;
        end else begin
            case (q.motion)
                TPMC_IDLE: begin
                    if (!q.remote) begin
                        if (press.load_point_press) begin
                            d.motion = TPMC_SEARCH_FWD;
                            d.travel_cnt = '0;
                            d.out.lamp_load_point = 1'b0;
                        end else if (press.rewind_press) begin
                            d.motion = TPMC_REWIND;
                            d.out.end_marker_lamp = 1'b0;
                            d.out.lamp_load_point = 1'b0;
                        end else if (press.forward_press) begin
                            d.motion = TPMC_FWD;
                            d.out.lamp_load_point = 1'b0;
                        end else if (press.reverse_press) begin
                            // Nothing to do when already at the start marker
                            if (!start_marker) begin
                                d.motion = TPMC_REV;
                                d.out.lamp_load_point = 1'b0;
                            end
                        end
                    end else if (go_rewind) begin
                        d.motion = TPMC_REWIND;
                        d.out.end_marker_lamp = 1'b0;
                        d.out.lamp_load_point = 1'b0;
                    end else if (go_fwd) begin
                        d.motion = TPMC_FWD;
                        d.out.lamp_load_point = 1'b0;
                    end else if (go_rev && !start_marker) begin
                        d.motion = TPMC_REV;
                        d.out.lamp_load_point = 1'b0;
                    end
                end
                TPMC_SEARCH_FWD: begin
                    if (start_marker) begin
                        d.motion = TPMC_IDLE;
                        d.out.lamp_load_point = 1'b1;
                    end else if (end_marker) begin
                        d.motion = TPMC_IDLE;
                        d.out.end_marker_lamp = 1'b1;
                    end else if (q.travel_cnt == SEARCH_LIMIT) begin
                        d.motion = TPMC_SEARCH_REV;
                    end
                end
                TPMC_SEARCH_REV: begin
                    if (start_marker) begin
                        d.motion = TPMC_IDLE;
                        d.out.lamp_load_point = 1'b1;
                    end
                end
                TPMC_REWIND: begin
                    if (start_marker) begin
                        d.motion = TPMC_IDLE;
                    end
                end
                TPMC_FWD: begin
                    // Start marker is not looked at here
                    if (end_marker) begin
                        d.motion = TPMC_IDLE;
                        d.out.end_marker_lamp = 1'b1;
                    end
                end
                TPMC_REV: begin
                    if (start_marker) begin
                        d.motion = TPMC_IDLE;
                    end
                end
                default: begin
                    d.motion = TPMC_IDLE;
                end
            endcase
            if (go_stop && (q.motion != TPMC_IDLE)) begin
                d.motion = TPMC_IDLE;
            end
        end

        // A marker seen in the cycle of a halt press still latches its lamp
        if (start_marker && ((q.motion == TPMC_SEARCH_FWD)
                || (q.motion == TPMC_SEARCH_REV))) begin
            d.out.lamp_load_point = 1'b1;
        end
        if (end_marker && ((q.motion == TPMC_FWD) || (q.motion == TPMC_SEARCH_FWD))) begin
            d.out.end_marker_lamp = 1'b1;
        end

        // Outputs follow the next state so they leave straight from flops
        d.out.motor_fwd = (d.motion == TPMC_SEARCH_FWD) || (d.motion == TPMC_FWD);
        d.out.motor_rev = (d.motion == TPMC_SEARCH_REV) || (d.motion == TPMC_REV);
        d.out.motor_rewind = (d.motion == TPMC_REWIND);
        d.out.vacuum_release = (d.motion == TPMC_REWIND);
        d.out.lamp_local = !d.remote;
        d.out.lamp_remote = d.remote;
        d.out.lamp_rewind = (d.motion == TPMC_REWIND);
        d.out.lamp_forward = (d.motion == TPMC_FWD);
        d.out.lamp_reverse = (d.motion == TPMC_REV);
        d.out.lamp_density = d.remote ? tpmc_density_lamps(d.density) : 3'h0;
        d.out.lamp_write_enable = ring_present;
        d.out.unit_selected = tpmc_unit_match(unit_number_switch, d.unit_addr);

        // One wait cycle then pready; read data captured with it
        d.pready = psel && penable && !q.pready;
        d.pslverr = 1'b0;
        if (!d.pready) begin
            d.prdata = 32'h0;
        end else begin
            case (paddr)
                `TPMC_REG_CMD: begin
                    d.prdata = {27'h0, q.unit_addr, q.density};
                end
                `TPMC_REG_STATUS: begin
                    d.prdata = {21'h0, end_marker, start_marker, ring_present,
                                q.out.unit_selected, q.out.end_marker_lamp,
                                q.out.lamp_load_point,
                                (q.motion == TPMC_SEARCH_FWD) || (q.motion == TPMC_SEARCH_REV),
                                q.out.motor_rewind, q.out.motor_rev, q.out.motor_fwd,
                                q.remote};
                end
                `TPMC_REG_TRAVEL: begin
                    d.prdata = {{(32 - `TPMC_TRAVEL_W){1'b0}}, q.travel_cnt};
                end
                default: begin
                    d.prdata = 32'h0;
                    d.pslverr = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= TPMC_RST;
        end else begin
            q <= d;
        end
    end

    assign prdata = q.prdata;
    assign pready = q.pready;
    assign pslverr = q.pslverr;
    assign motor_fwd = q.out.motor_fwd;
    assign motor_rev = q.out.motor_rev;
    assign motor_rewind = q.out.motor_rewind;
    assign vacuum_release = q.out.vacuum_release;
    assign lamp_local = q.out.lamp_local;
    assign lamp_remote = q.out.lamp_remote;
    assign lamp_load_point = q.out.lamp_load_point;
    assign lamp_rewind = q.out.lamp_rewind;
    assign lamp_forward = q.out.lamp_forward;
    assign lamp_reverse = q.out.lamp_reverse;
    assign lamp_density = q.out.lamp_density;
    assign lamp_write_enable = q.out.lamp_write_enable;
    assign end_marker_lamp = q.out.end_marker_lamp;
    assign unit_selected = q.out.unit_selected;

endmodule : tpmc_top

// *** testbench/tpmc_top_props.sv ***
// Concurrent checks on the ports of the tape panel motion control top level
module tpmc_top_props (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic start_marker,
    input wire logic end_marker,
    input wire logic ring_present,
    input wire logic [3:0] unit_number_switch,
    input wire logic motor_fwd,
    input wire logic motor_rev,
    input wire logic motor_rewind,
    input wire logic vacuum_release,
    input wire logic lamp_local,
    input wire logic lamp_remote,
    input wire logic lamp_load_point,
    input wire logic lamp_rewind,
    input wire logic lamp_forward,
    input wire logic lamp_reverse,
    input wire logic [2:0] lamp_density,
    input wire logic lamp_write_enable,
    input wire logic end_marker_lamp,
    input wire logic unit_selected
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    a_one_mode: assert property (lamp_local ^ lamp_remote)
        else $error("mode lamps not exclusive");
    a_dens_remote: assert property (lamp_density != 3'h0 |-> lamp_remote && $onehot(lamp_density))
        else $error("density lamp outside remote mode");
    a_vac_rewind: assert property (vacuum_release == motor_rewind)
        else $error("columns released outside rewind");
    a_rw_lamp: assert property (!lamp_remote |-> lamp_rewind == motor_rewind)
        else $error("rewind lamp disagrees with rewind");
    a_fwd_lamp: assert property (lamp_forward |-> motor_fwd && !vacuum_release)
        else $error("forward lamp without forward motion");
    a_rev_lamp: assert property (lamp_reverse |-> motor_rev && !vacuum_release)
        else $error("reverse lamp without reverse motion");
    a_end_stop: assert property (end_marker && motor_fwd |=> !motor_fwd && end_marker_lamp)
        else $error("no stop at end marker");
    a_start_stop: assert property (start_marker && lamp_reverse |=> !motor_rev && !lamp_reverse)
        else $error("reverse runs past start marker");
    a_search_found: assert property ((motor_fwd || motor_rev) && !lamp_forward && !lamp_reverse
        && !lamp_remote && start_marker |=> lamp_load_point && !motor_fwd && !motor_rev)
        else $error("search did not stop at marker");
    a_we_follow: assert property (1'h1 |=> lamp_write_enable == $past(ring_present))
        else $error("write enable lamp lags ring sensor");
    a_unit_range: assert property ((unit_number_switch > 4'h7) [*2] |-> !unit_selected)
        else $error("unit selected at unusable switch position");
endmodule : tpmc_top_props

bind tpmc_top tpmc_top_props i_tpmc_top_props (
    .pclk, .presetn, .start_marker, .end_marker, .ring_present, .unit_number_switch,
    .motor_fwd, .motor_rev, .motor_rewind, .vacuum_release, .lamp_local, .lamp_remote,
    .lamp_load_point, .lamp_rewind, .lamp_forward, .lamp_reverse, .lamp_density,
    .lamp_write_enable, .end_marker_lamp, .unit_selected
);

// *** testbench/tpmc_tape_model.sv ***
// Tape reel model: head position, marker sensors and travel pulses
module tpmc_tape_model (
    input wire logic pclk,
    input wire logic motor_fwd,
    input wire logic motor_rev,
    input wire logic motor_rewind,
    input wire logic load,
    input wire logic [15:0] load_pos,
    output logic start_marker,
    output logic end_marker,
    output logic travel_pulse
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [15:0] pos = 16'h0000;
    logic phase = 1'h0;
    // Strips are one step long, so a late stop runs past them
    assign start_marker = pos == 16'h0064;
    assign end_marker = pos == 16'h00c8;
    // Stands still whenever no motor runs
    assign travel_pulse = phase;
    always @(posedge pclk) begin
        if (load) begin
            pos <= load_pos;
        end else if (motor_fwd || motor_rev || motor_rewind) begin
            phase <= !phase;
            // Rewind steps every cycle, normal speed every other
            if (phase || motor_rewind) begin
                pos <= motor_fwd ? pos + 16'h0001 : pos - 16'h0001;
            end
        end
    end
endmodule : tpmc_tape_model

// *** testbench/tpmc_top_tb_top.sv ***
// Self-checking bench for the tape panel motion control block
module tpmc_top_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, ring_present, load;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [5:0] btn;
    logic [3:0] unit_number_switch;
    logic [15:0] load_pos;
    logic start_marker, end_marker, travel_pulse, motor_fwd, motor_rev, motor_rewind;
    logic vacuum_release, lamp_local, lamp_remote, lamp_load_point, lamp_rewind;
    logic lamp_forward, lamp_reverse, lamp_write_enable, end_marker_lamp, unit_selected;
    logic [2:0] lamp_density;
    logic [4:0] obs;
    int fail_count = 0;
    int tests_run = 0;

    assign obs = {lamp_reverse, lamp_rewind, lamp_forward, motor_rev, lamp_load_point};

    initial begin
        pclk = 1'h0;
        forever #5 pclk = ~pclk;
    end

    // Short debounce and one pulse per foot keep the run brief
    tpmc_top #(.DEBOUNCE_CYCLES(4), .PULSES_PER_FT(1)) i_tpmc_top (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .btn_local(btn[0]), .btn_remote(btn[1]), .btn_load_point(btn[2]),
        .btn_rewind(btn[3]), .btn_forward(btn[4]), .btn_reverse(btn[5]), .start_marker,
        .end_marker, .ring_present, .travel_pulse, .unit_number_switch, .motor_fwd,
        .motor_rev, .motor_rewind, .vacuum_release, .lamp_local, .lamp_remote,
        .lamp_load_point, .lamp_rewind, .lamp_forward, .lamp_reverse, .lamp_density,
        .lamp_write_enable, .end_marker_lamp, .unit_selected
    );

    tpmc_tape_model i_tpmc_tape_model (
        .pclk, .motor_fwd, .motor_rev, .motor_rewind, .load, .load_pos, .start_marker,
        .end_marker, .travel_pulse
    );

    task automatic conclude;
        $display("checks %0d, mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : conclude

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            fail_count++;
            $display("unexpected %s: expected %0h, seen %0h", n, e, g);
        end
    endtask : chk

    task automatic wt(input int i, input logic v, input int lim);
        for (int n = 0; n < lim && obs[i] !== v; n++) begin
            @(posedge pclk);
        end
        if (obs[i] !== v) begin
            fail_count++;
            $display("unexpected timeout on output %0d", i);
            conclude();
        end
    endtask : wt

    // Held long enough to clear the debouncer, then released
    task automatic press(input int b);
        @(posedge pclk);
        btn[b] <= 1'h1;
        repeat (12) @(posedge pclk);
        btn[b] <= 1'h0;
        repeat (12) @(posedge pclk);
    endtask : press

    task automatic place(input logic [15:0] p);
        @(posedge pclk);
        load <= 1'h1;
        load_pos <= p;
        @(posedge pclk);
        load <= 1'h0;
    endtask : place

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        for (int n = 0; n < 20; n++) begin
            @(posedge pclk);
            if (pready === 1'h1) break;
        end
        if (pready !== 1'h1) begin
            fail_count++;
            $display("unexpected timeout on pready");
            conclude();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask : apb

    task automatic t_search;
        place(16'h005a);
        press(2);
        wt(0, 1'h1, 100);
        chk("near search", 2'h0, {motor_fwd, motor_rev});
        place(16'h006e);
        press(2);
        chk("search fwd", 1'h1, motor_fwd);
        wt(1, 1'h1, 100);
        chk("span", 1'h1, i_tpmc_tape_model.pos > 16'h0085 && i_tpmc_tape_model.pos < 16'h0089);
        wt(0, 1'h1, 200);
        chk("far search", 2'h0, {motor_fwd, motor_rev});
        apb(1'h0, 12'h008, 32'h0);
        chk("travel", 32'h00000019, rd);
    endtask : t_search

    task automatic t_motion;
        press(4);
        chk("fwd run", 3'h7, {motor_fwd, lamp_forward, !vacuum_release});
        wt(2, 1'h0, 400);
        chk("fwd end", 3'h1, {motor_fwd, lamp_forward, end_marker_lamp});
        press(3);
        chk("rewind", 4'he, {motor_rewind, vacuum_release, lamp_rewind, end_marker_lamp});
        wt(3, 1'h0, 300);
        chk("rewind end", 3'h0, {motor_rewind, vacuum_release, lamp_load_point});
        press(5);
        chk("rev run", 2'h3, {motor_rev, lamp_reverse});
        press(0);
        chk("local halt", 2'h0, {motor_rev, lamp_reverse});
        place(16'h006e);
        press(5);
        wt(4, 1'h0, 100);
        chk("rev end", 2'h1, {motor_rev, start_marker});
    endtask : t_motion

    task automatic t_remote;
        apb(1'h1, 12'h000, 32'h0000000e);
        unit_number_switch <= 4'h3;
        ring_present <= 1'h1;
        press(4);
        press(1);
        chk("remote", 4'h2, {motor_fwd, lamp_forward, lamp_remote, lamp_local});
        chk("density", 3'h2, lamp_density);
        chk("unit", 1'h1, unit_selected);
        chk("ring", 1'h1, lamp_write_enable);
        apb(1'h0, 12'h004, 32'h0);
        chk("status", 1'h1, rd[0]);
        apb(1'h0, 12'h00c, 32'h0);
        chk("unmapped", 1'h1, err);
        apb(1'h0, 12'h000, 32'h0);
        chk("cmd read", 32'h0000000e, rd);
        apb(1'h1, 12'h000, 32'h0000010e);
        repeat (2) @(posedge pclk);
        chk("remote fwd", 2'h3, {motor_fwd, lamp_forward});
        apb(1'h1, 12'h000, 32'h0000080e);
        repeat (2) @(posedge pclk);
        chk("remote stop", 2'h0, {motor_fwd, lamp_forward});
        apb(1'h1, 12'h000, 32'h0000040e);
        repeat (2) @(posedge pclk);
        chk("remote rewind", 2'h3, {motor_rewind, lamp_rewind});
        wt(3, 1'h0, 100);
        unit_number_switch <= 4'h9;
        repeat (3) @(posedge pclk);
        chk("unit 9", 1'h0, unit_selected);
        apb(1'h1, 12'h000, 32'h0000010e);
        repeat (2) @(posedge pclk);
        chk("unit 9 order", 1'h0, motor_fwd);
        press(0);
        chk("halt", 5'h10, {lamp_local, lamp_remote, lamp_density});
    endtask : t_remote

    initial begin
        presetn = 1'h0;
        psel = 1'h0;
        penable = 1'h0;
        pwrite = 1'h0;
        paddr = 12'h000;
        pwdata = 32'h0;
        btn = 6'h00;
        unit_number_switch = 4'h0;
        ring_present = 1'h0;
        load = 1'h0;
        load_pos = 16'h0000;
        repeat (8) @(posedge pclk);
        presetn <= 1'h1;
        @(posedge pclk);
        chk("power", 3'h4, {lamp_local, lamp_remote, motor_fwd});
        t_search();
        t_motion();
        t_remote();
        conclude();
    end
endmodule : tpmc_top_tb_top
